// ===== phy_access_consts.svh
// Offsets, field positions, reset values and link request codes
// Assumes byte addresses on a 32-bit register bus
`ifndef PHY_ACCESS_CONSTS_SVH
`define PHY_ACCESS_CONSTS_SVH
// Register byte offsets
`define OFF_PHY_ACCESS 8'h00
`define OFF_NODE_IDENT 8'h04
`define OFF_EVT_STATUS 8'h08
`define OFF_EVT_CLEAR 8'h0C
`define OFF_EVT_ENABLE 8'h10
// Access register fields
`define F_RD_DONE 31
`define F_RD_ADDR_HI 27
`define F_RD_ADDR_LO 24
`define F_RD_DATA_HI 23
`define F_RD_DATA_LO 16
`define F_RD_REQ 15
`define F_WR_REQ 14
`define F_REG_ADDR_HI 11
`define F_REG_ADDR_LO 8
`define F_WR_DATA_HI 7
`define F_WR_DATA_LO 0
// Node identity register fields
`define F_ID_VALID 31
`define F_ROOT 30
`define F_CPS 27
`define F_BUS_HI 15
`define F_BUS_LO 6
`define F_NODE_HI 5
`define F_NODE_LO 0
`define BUS_NUM_RST 10'h3FF
// Contents of PHY register 0
`define R0_ID_HI 7
`define R0_ID_LO 2
`define R0_ROOT 1
`define R0_CPS 0
// Event bits
`define EVT_W 2
`define EVT_REG_RCVD 0
`define EVT_REG0_RPT 1
// Link request frames
`define LREQ_RD_TYPE 3'h4
`define LREQ_WR_TYPE 3'h5
`define LREQ_RD_LEN 5'h09
`define LREQ_WR_LEN 5'h11
`endif

// ===== phy_access_pkg.sv
// Types shared by the PHY register access unit
// Assumes nothing of its surroundings
package phy_access_pkg;
  typedef enum logic [1:0] {LREQ_IDLE = 2'b00, LREQ_SHIFT = 2'b01} lreq_state_type;
  typedef logic [3:0] phy_addr_type;
  typedef logic [7:0] phy_data_type;
  typedef enum logic [2:0] {
    SEL_ACCESS = 3'h0, SEL_NODE = 3'h1, SEL_STATUS = 3'h2,
    SEL_CLEAR = 3'h3, SEL_ENABLE = 3'h4, SEL_NONE = 3'h7
  } reg_sel_type;
endpackage

// ===== phy_req_if.sv
// Request channel from register file to link request serializer
// Assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface phy_req_if import phy_access_pkg::*; ();
  logic valid;
  logic write;
  phy_addr_type addr;
  phy_data_type data;
  logic busy;
  logic sent;
  modport ctrl(output valid, output write, output addr, output data, input busy, input sent);
  modport ser(input valid, input write, input addr, input data, output busy, output sent);
endinterface
`default_nettype wire

// ===== lreq_serializer.sv
// Shifts PHY register read and write requests out on the link request pin
// Assumes a request stays valid until sent is seen
`timescale 1ns/1ps
`default_nettype none
`include "phy_access_consts.svh"
module lreq_serializer import phy_access_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  phy_req_if.ser req,
  output logic o_lreq
);
  lreq_state_type state_r;
  logic [16:0] shift_r;
  logic [4:0] cnt_r;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= LREQ_IDLE;
      shift_r <= '0;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        LREQ_IDLE: begin
          if (req.valid) begin
            state_r <= LREQ_SHIFT;
            if (req.write) begin
              shift_r <= {1'b1, `LREQ_WR_TYPE, req.addr, req.data, 1'b0};
              cnt_r <= `LREQ_WR_LEN;
            end else begin
              shift_r <= {1'b1, `LREQ_RD_TYPE, req.addr, 1'b0, 8'h00};
              cnt_r <= `LREQ_RD_LEN;
            end
          end
        end
        LREQ_SHIFT: begin
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h01) begin
            state_r <= LREQ_IDLE;
            shift_r <= '0;
          end else begin
            shift_r <= {shift_r[15:0], 1'b0};
          end
        end
        default: state_r <= LREQ_IDLE;
      endcase
    end
  end

  assign o_lreq = shift_r[16];
  assign req.busy = (state_r == LREQ_SHIFT);
  assign req.sent = (state_r == LREQ_SHIFT) && (cnt_r == 5'h01);

  a_read_frame_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_r == LREQ_IDLE && req.valid && !req.write) |=> !req.sent [*8] ##1 req.sent)
    else $error("read request frame length wrong");
  a_read_no_data: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_r == LREQ_IDLE && req.valid && !req.write) |=> shift_r[8:0] == 9'h000)
    else $error("write value shifted in a read frame");
  a_write_frame_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_r == LREQ_IDLE && req.valid && req.write) |-> ##17 req.sent)
    else $error("write request frame length wrong");
endmodule
`default_nettype wire

// ===== evt_irq.sv
// Sticky event status, enable mask and level interrupt
// Assumes set pulses and write strobes last one cycle
`timescale 1ns/1ps
`default_nettype none
module evt_irq #(
  parameter int W = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_set,
  input wire logic i_clr_wr,
  input wire logic i_en_wr,
  input wire logic [W-1:0] i_wdata,
  output logic [W-1:0] o_status,
  output logic [W-1:0] o_enable,
  output logic o_irq
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          o_status[g] <= 1'b0;
        end else if (i_set[g]) begin
          o_status[g] <= 1'b1;
        end else if (i_clr_wr && i_wdata[g]) begin
          o_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_enable <= '0;
    end else if (i_en_wr) begin
      o_enable <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(o_status & o_enable);
    end
  end

  a_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    |(o_status & o_enable) |=> o_irq)
    else $error("interrupt not raised for enabled event");
endmodule
`default_nettype wire

// ===== phy_register_access.sv
// PHY register access unit: APB register file, link request and status capture
// Assumes PHY status transfers arrive decoded as one-cycle pulses
// Function
// - Read bit clears after request sent
// - Returned register sets done, then event
// - Store returned address and value
// - Write bit clears after request sent
// - Register 0 while pending updates both
// - Register 0 while idle updates identity only
// - Explicit register 0 read updates both
// - Request bit set clears done flag
// - Write value ignored on reads
// - Request bits reset to zero
// - Full PHY register map addressable
// - Node number loaded from PHY report
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "phy_access_consts.svh"
module phy_register_access import phy_access_pkg::*; #(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // PHY link
  output logic o_lreq,
  input wire logic i_stat_valid,
  input wire logic [3:0] i_stat_addr,
  input wire logic [7:0] i_stat_data,
  // Interrupt
  output logic o_irq
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_b;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic rd_r;
  logic wr_r;
  logic await_r;
  logic rd_done_r;
  phy_addr_type rd_addr_r;
  phy_data_type rd_data_r;
  phy_addr_type reg_addr_r;
  phy_data_type wr_data_r;
  logic [9:0] bus_num_r;
  logic [5:0] node_num_r;
  logic id_valid_r;
  logic root_r;
  logic cps_r;
  logic rcv_evt_r;
  logic reg0_evt_r;
  logic [`EVT_W-1:0] evt_status;
  logic [`EVT_W-1:0] evt_enable;
  logic [31:0] access_word;
  logic [31:0] node_word;
  logic [31:0] rd_word;
  reg_sel_type sel;
  logic access_done;
  logic wr_en;
  logic acc_wr;
  logic req_busy;
  logic req_bits;
  logic pending;
  logic take_access;
  logic reg0_rpt;

  phy_req_if preq ();

  function automatic reg_sel_type reg_sel(input logic [AW-1:0] a);
    unique case (a)
      AW'(`OFF_PHY_ACCESS): reg_sel = SEL_ACCESS;
      AW'(`OFF_NODE_IDENT): reg_sel = SEL_NODE;
      AW'(`OFF_EVT_STATUS): reg_sel = SEL_STATUS;
      AW'(`OFF_EVT_CLEAR): reg_sel = SEL_CLEAR;
      AW'(`OFF_EVT_ENABLE): reg_sel = SEL_ENABLE;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction

  // Reset release through two stages
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_b = rst_sync_r;

  // APB decode; one wait state in every access phase
  assign sel = reg_sel(i_paddr);
  assign access_done = i_psel && i_penable && pready_r;
  assign wr_en = access_done && i_pwrite;
  assign acc_wr = wr_en && (sel == SEL_ACCESS);
  assign req_busy = rd_r || wr_r;
  assign req_bits = i_pwdata[`F_RD_REQ] || i_pwdata[`F_WR_REQ];

  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= i_psel && i_penable && !pready_r;
      pslverr_r <= i_psel && i_penable && !pready_r && (sel == SEL_NONE);
      if (i_psel && i_penable && !pready_r && !i_pwrite) begin
        prdata_r <= rd_word;
      end
    end
  end
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_prdata = prdata_r;

  always_comb begin
    access_word = '0;
    access_word[`F_RD_DONE] = rd_done_r;
    access_word[`F_RD_ADDR_HI:`F_RD_ADDR_LO] = rd_addr_r;
    access_word[`F_RD_DATA_HI:`F_RD_DATA_LO] = rd_data_r;
    access_word[`F_RD_REQ] = rd_r;
    access_word[`F_WR_REQ] = wr_r;
    access_word[`F_REG_ADDR_HI:`F_REG_ADDR_LO] = reg_addr_r;
    access_word[`F_WR_DATA_HI:`F_WR_DATA_LO] = wr_data_r;
  end

  always_comb begin
    node_word = '0;
    node_word[`F_ID_VALID] = id_valid_r;
    node_word[`F_ROOT] = root_r;
    node_word[`F_CPS] = cps_r;
    node_word[`F_BUS_HI:`F_BUS_LO] = bus_num_r;
    node_word[`F_NODE_HI:`F_NODE_LO] = node_num_r;
  end

  always_comb begin
    rd_word = '0;
    unique case (sel)
      SEL_ACCESS: rd_word = access_word;
      SEL_NODE: rd_word = node_word;
      SEL_STATUS: rd_word[`EVT_W-1:0] = evt_status;
      SEL_ENABLE: rd_word[`EVT_W-1:0] = evt_enable;
      SEL_CLEAR: rd_word = '0;
      SEL_NONE: rd_word = '0;
    endcase
  end

  // Request bits; a new request is taken only when none is outstanding
  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (preq.sent) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (acc_wr && !req_busy) begin
      rd_r <= i_pwdata[`F_RD_REQ];
      wr_r <= i_pwdata[`F_WR_REQ] && !i_pwdata[`F_RD_REQ];
    end
  end

  // Address and value frozen while a request is shifted out
  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_addr_r <= '0;
      wr_data_r <= '0;
    end else if (acc_wr && !req_busy) begin
      reg_addr_r <= i_pwdata[`F_REG_ADDR_HI:`F_REG_ADDR_LO];
      wr_data_r <= i_pwdata[`F_WR_DATA_HI:`F_WR_DATA_LO];
    end
  end

  // Read sent, answer not yet back
  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      await_r <= 1'b0;
    end else if (preq.sent && rd_r) begin
      await_r <= 1'b1;
    end else if (i_stat_valid && (i_stat_addr == reg_addr_r)) begin
      await_r <= 1'b0;
    end else if (acc_wr && !req_busy && req_bits) begin
      await_r <= 1'b0;
    end
  end

  assign pending = rd_r || wr_r || await_r;
  assign reg0_rpt = i_stat_valid && (i_stat_addr == 4'h0);
  // Register 0 reaches the access register only while a request is pending
  assign take_access = i_stat_valid && ((i_stat_addr != 4'h0) || pending);

  // Received register capture
  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_addr_r <= '0;
      rd_data_r <= '0;
    end else if (take_access) begin
      rd_addr_r <= i_stat_addr;
      rd_data_r <= i_stat_data;
    end
  end

  // Done flag; a received register wins over a clearing write
  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_done_r <= 1'b0;
    end else if (take_access) begin
      rd_done_r <= 1'b1;
    end else if (acc_wr && req_bits) begin
      rd_done_r <= 1'b0;
    end
  end

  // Receive pulse rises with the done flag, register 0 pulse with the node fields; status bits follow one cycle later
  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rcv_evt_r <= 1'b0;
      reg0_evt_r <= 1'b0;
    end else begin
      rcv_evt_r <= take_access;
      reg0_evt_r <= reg0_rpt;
    end
  end

  // Node identity from register 0 reports
  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      node_num_r <= '0;
      id_valid_r <= 1'b0;
      root_r <= 1'b0;
      cps_r <= 1'b0;
    end else if (reg0_rpt) begin
      node_num_r <= i_stat_data[`R0_ID_HI:`R0_ID_LO];
      id_valid_r <= 1'b1;
      root_r <= i_stat_data[`R0_ROOT];
      cps_r <= i_stat_data[`R0_CPS];
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_num_r <= `BUS_NUM_RST;
    end else if (wr_en && (sel == SEL_NODE)) begin
      bus_num_r <= i_pwdata[`F_BUS_HI:`F_BUS_LO];
    end
  end

  assign preq.valid = rd_r || wr_r;
  assign preq.write = wr_r;
  assign preq.addr = reg_addr_r;
  assign preq.data = wr_data_r;

  lreq_serializer u_lreq (
    .i_core_clk(i_core_clk),
    .i_rst_b(rst_b),
    .req(preq.ser),
    .o_lreq(o_lreq)
  );

  evt_irq #(.W(`EVT_W)) u_irq (
    .i_core_clk(i_core_clk),
    .i_rst_b(rst_b),
    .i_set({reg0_evt_r, rcv_evt_r}),
    .i_clr_wr(wr_en && (sel == SEL_CLEAR)),
    .i_en_wr(wr_en && (sel == SEL_ENABLE)),
    .i_wdata(i_pwdata[`EVT_W-1:0]),
    .o_status(evt_status),
    .o_enable(evt_enable),
    .o_irq(o_irq)
  );

  // Request bits held until the frame is out
  a_rd_clear_sent: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    (preq.sent && rd_r) |=> !rd_r && await_r)
    else $error("read bit not cleared after send");
  a_rd_held: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    (rd_r && !preq.sent) |=> rd_r)
    else $error("read bit cleared before send");
  a_req_held_frame: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    preq.busy |-> req_busy)
    else $error("request bit dropped during frame");
  a_wr_clear_sent: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    (preq.sent && wr_r) |=> !wr_r)
    else $error("write bit not cleared after send");
  a_wr_held: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    (wr_r && !preq.sent) |=> wr_r)
    else $error("write bit cleared before send");
  a_done_then_evt: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    take_access |=> rd_done_r && rcv_evt_r ##1 evt_status[`EVT_REG_RCVD])
    else $error("done flag or event missing");
  a_capture_fields: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    take_access |=> rd_addr_r == $past(i_stat_addr) && rd_data_r == $past(i_stat_data))
    else $error("returned register not captured");
  a_reg0_idle_only: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    (reg0_rpt && !pending) |=> $stable(rd_data_r) && $stable(rd_addr_r) && !$rose(rd_done_r)
    && node_num_r == $past(i_stat_data[`R0_ID_HI:`R0_ID_LO]))
    else $error("idle register 0 report touched access register");
  a_reg0_pending_both: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    (reg0_rpt && pending) |=> rd_data_r == $past(i_stat_data)
    && node_num_r == $past(i_stat_data[`R0_ID_HI:`R0_ID_LO]) && id_valid_r)
    else $error("pending register 0 report not routed to both");
  a_explicit_reg0: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    (reg0_rpt && await_r && reg_addr_r == 4'h0) |=> rd_done_r && rd_addr_r == 4'h0 && id_valid_r)
    else $error("explicit register 0 read not delivered");
  // Node fields follow every register 0 report
  a_node_from_report: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    reg0_rpt |=> id_valid_r && root_r == $past(i_stat_data[`R0_ROOT])
    && cps_r == $past(i_stat_data[`R0_CPS]))
    else $error("register 0 report not loaded into node fields");
  a_done_clear_req: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    (acc_wr && req_bits && !take_access) |=> !rd_done_r)
    else $error("done flag not cleared by request");
  a_one_request: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    !(rd_r && wr_r))
    else $error("read and write requests both set");
  a_req_frozen: assert property (@(posedge i_core_clk) disable iff (!rst_b)
    req_busy |=> $stable(reg_addr_r) && $stable(wr_data_r))
    else $error("request fields changed while outstanding");

  c_read_done: cover property (@(posedge i_core_clk) disable iff (!rst_b)
    (preq.sent && rd_r) ##[1:40] take_access);
  c_write_sent: cover property (@(posedge i_core_clk) disable iff (!rst_b) preq.sent && wr_r);
  c_reg0_idle: cover property (@(posedge i_core_clk) disable iff (!rst_b) reg0_rpt && !pending);
  c_reg0_pending: cover property (@(posedge i_core_clk) disable iff (!rst_b) reg0_rpt && pending);
  c_irq_raised: cover property (@(posedge i_core_clk) disable iff (!rst_b) $rose(o_irq));
endmodule
`default_nettype wire

// ===== phy_model.sv
// PHY-side model: decodes link request frames, holds 16 registers, returns status
// Assumes the link request pin idles low and is sampled on the rising edge
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  // Clock
  input wire logic i_core_clk,
  // Link side
  input wire logic i_lreq,
  output logic o_stat_valid,
  output logic [3:0] o_stat_addr,
  output logic [7:0] o_stat_data
);
  logic [7:0] regs [16];
  int lat = 1;
  task automatic send(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_stat_valid <= 1'b1;
    o_stat_addr <= a;
    o_stat_data <= d;
    @(posedge i_core_clk);
    o_stat_valid <= 1'b0;
    // Released lines show the inverse, never stale data
    o_stat_addr <= ~a;
    o_stat_data <= ~d;
  endtask
  initial begin
    logic [2:0] ty;
    logic [3:0] a;
    logic [7:0] d;
    o_stat_valid = 1'b0;
    o_stat_addr = 4'hF;
    o_stat_data = 8'hFF;
    for (int i = 0; i < 16; i++) regs[i] = 8'(i * 37 + 5);
    forever begin
      @(posedge i_core_clk);
      if (i_lreq === 1'b1) begin
        repeat (3) begin
          @(posedge i_core_clk);
          ty = {ty[1:0], i_lreq};
        end
        repeat (4) begin
          @(posedge i_core_clk);
          a = {a[2:0], i_lreq};
        end
        if (ty == 3'b101) begin
          repeat (8) begin
            @(posedge i_core_clk);
            d = {d[6:0], i_lreq};
          end
          regs[a] = d;
        end
        // Stop bit
        @(posedge i_core_clk);
        if (ty == 3'b100) begin
          repeat (lat) @(posedge i_core_clk);
          send(a, regs[a]);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== phy_register_access_tb.sv
// Self-checking bench for the PHY register access unit
// Assumes the PHY model file and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "phy_access_consts.svh"
module phy_register_access_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, lreq, sv, irq;
  logic [3:0] sa;
  logic [7:0] sd;
  logic [7:0] shadow [16];
  int n_fail = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  phy_register_access phy_register_access_i (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_lreq(lreq),
    .i_stat_valid(sv), .i_stat_addr(sa), .i_stat_data(sd), .o_irq(irq));
  phy_model phy_model_i (.i_core_clk(clk), .i_lreq(lreq), .o_stat_valid(sv),
    .o_stat_addr(sa), .o_stat_data(sd));
  function automatic logic [31:0] acc_exp(input logic [3:0] a, input logic [7:0] d);
    return {1'b1, 3'h0, a, d, 16'h0};
  endfunction
  function automatic logic [31:0] node_exp(input logic [7:0] d);
    return (32'(d[1]) << `F_ROOT) | (32'(d[0]) << `F_CPS) | 32'(d[7:2]);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 40) chk("pready", 32'h1, 32'h0);
  endtask
  task automatic rr(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask
  task automatic ww(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask
  task automatic wait_bit(input int b, input logic v, output logic [31:0] r);
    int n;
    n = 0;
    do begin
      rr(`OFF_PHY_ACCESS, r);
      n++;
    end while (r[b] !== v && n < 40);
    chk("access bit", {31'h0, v}, {31'h0, r[b]});
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim;
  end
  initial begin
    logic [31:0] r, snap;
    logic [3:0] a;
    logic [7:0] d;
    logic en, e;
    logic [9:0] bn;
    void'($urandom(68));
    for (int i = 0; i < 16; i++) shadow[i] = 8'(i * 37 + 5);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rr(`OFF_PHY_ACCESS, r);
    chk("access reset", 32'h0, r & 32'h0000C000);
    rr(`OFF_NODE_IDENT, r);
    chk("bus number reset", 32'(`BUS_NUM_RST) << `F_BUS_LO, r & 32'h0000FFC0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    rr(`OFF_EVT_CLEAR, r);
    chk("clear reads zero", 32'h0, r);
    bn = 10'($urandom);
    ww(`OFF_NODE_IDENT, 32'(bn) << `F_BUS_LO);
    rr(`OFF_NODE_IDENT, r);
    chk("bus number", 32'(bn) << `F_BUS_LO, r & 32'h0000FFC0);
    for (int k = 0; k < 12; k++) begin
      a = (k == 0) ? 4'h0 : 4'($urandom_range(0, 15));
      d = 8'($urandom);
      en = 1'($urandom);
      phy_model_i.lat = $urandom_range(1, 8);
      ww(`OFF_EVT_ENABLE, {31'h0, en});
      if (k % 2 == 1) begin
        ww(`OFF_PHY_ACCESS, (32'h1 << `F_WR_REQ) | {20'h0, a, d});
        wait_bit(`F_WR_REQ, 1'b0, r);
        shadow[a] = d;
        d = ~d;
      end
      // Read with a random write value that must be ignored
      ww(`OFF_PHY_ACCESS, (32'h1 << `F_RD_REQ) | {20'h0, a, d});
      rr(`OFF_PHY_ACCESS, r);
      chk("done after request", 32'h0, {31'h0, r[`F_RD_DONE]});
      wait_bit(`F_RD_REQ, 1'b0, r);
      wait_bit(`F_RD_DONE, 1'b1, r);
      chk("returned fields", acc_exp(a, shadow[a]), r & 32'hFFFFC000);
      if (a == 4'h0) begin
        rr(`OFF_NODE_IDENT, r);
        chk("node from read", node_exp(shadow[0]), r & 32'h4800003F);
      end
      repeat (2) @(posedge clk);
      rr(`OFF_EVT_STATUS, r);
      chk("received event", 32'h1, r & 32'h1);
      chk("irq level", {31'h0, en}, {31'h0, irq});
      ww(`OFF_EVT_CLEAR, 32'h3);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    // Unsolicited register 0 report with nothing pending
    rr(`OFF_PHY_ACCESS, snap);
    d = 8'($urandom);
    phy_model_i.send(4'h0, d);
    repeat (3) @(posedge clk);
    rr(`OFF_PHY_ACCESS, r);
    chk("access untouched", snap, r);
    rr(`OFF_NODE_IDENT, r);
    chk("node from report", node_exp(d), r & 32'h4800003F);
    rr(`OFF_EVT_STATUS, r);
    chk("report event only", 32'h2, r & 32'h3);
    ww(`OFF_EVT_ENABLE, 32'h2);
    rr(`OFF_EVT_ENABLE, r);
    chk("enable readback", 32'h2, r);
    chk("irq from report", 32'h1, {31'h0, irq});
    // Register 0 report while a write is still being sent
    d = 8'($urandom);
    ww(`OFF_PHY_ACCESS, (32'h1 << `F_WR_REQ) | 32'h000005A5);
    phy_model_i.send(4'h0, d);
    repeat (2) @(posedge clk);
    rr(`OFF_PHY_ACCESS, r);
    chk("pending report", acc_exp(4'h0, d) | 32'h4000, r & 32'hFFFFC000);
    rr(`OFF_NODE_IDENT, r);
    chk("node pending", node_exp(d), r & 32'h4800003F);
    wait_bit(`F_WR_REQ, 1'b0, r);
    ww(`OFF_PHY_ACCESS, (32'h1 << `F_RD_REQ) | 32'h00000500);
    wait_bit(`F_RD_DONE, 1'b1, r);
    chk("write landed", acc_exp(4'h5, 8'hA5), r & 32'hFFFFC000);
    end_sim;
  end
endmodule
`default_nettype wire
